// ### verilog/event_router_pkg.sv
// Constants and types shared by the event router
package event_router_pkg;
   // =====================================================================
   // Sizes
   localparam int unsigned CHANNELS = 8;
   localparam int unsigned SOURCES = 32;
   localparam int unsigned SEL_WIDTH = 8;
   localparam int unsigned DIV_SEL_WIDTH = 4;
   localparam int unsigned DIV_CNT_WIDTH = 15;
   // =====================================================================
   // Source selector values
   localparam logic [7:0] SEL_NONE = 8'h00;
   localparam logic [7:0] SEL_PRESCALER = 8'h01;
   localparam logic [7:0] SEL_SOURCE_BASE = 8'h20;
   // =====================================================================
   // Reset values
   localparam logic [7:0] SEL_RESET = 8'h00;
   localparam logic [3:0] DIV_SEL_RESET = 4'h0;
   localparam logic [14:0] DIV_CNT_RESET = 15'h0000;
   // =====================================================================
   // Largest divider exponent: 2**15 = 32768
   localparam logic [3:0] DIV_SEL_MAX = 4'hF;
   // Latency from generator to user, peripheral clock cycles
   localparam int unsigned ROUTE_LATENCY = 2;
   // =====================================================================
   // Event decode seen by a data-capable user
   typedef enum logic [1:0]
   {
      EVT_NONE = 2'b00,
      EVT_DATA_01 = 2'b01,
      EVT_DATA_02 = 2'b10,
      EVT_DATA_03 = 2'b11
   } data_event_type;
endpackage

// ### verilog/channel_divider.sv
// Per-channel peripheral clock prescaler emitting a one-cycle tick
`timescale 1ns/1ps
`default_nettype none
module channel_divider
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [3:0] div_sel,
   output logic tick
);
   logic [14:0] count_q;
   logic [14:0] count_d;
   logic [14:0] limit;
   logic [3:0] sel_eff;

   // =====================================================================
   // Divide by 2**div_sel, 1 up to 32768
   always_comb
   begin
      sel_eff = (div_sel > event_router_pkg::DIV_SEL_MAX) ? event_router_pkg::DIV_SEL_MAX
                                                            : div_sel;
      limit = 15'((32'h1 << sel_eff) - 32'h1);
      count_d = count_q + 15'h0001;
      tick = 1'b0;
      if (count_q >= limit)
      begin
         count_d = 15'h0000;
         tick = 1'b1;
      end
      if (!rst_n)
      begin
         count_d = event_router_pkg::DIV_CNT_RESET;
      end
   end

   always_ff @(posedge clk)
   begin
      count_q <= count_d;
   end

   div_period_a: assert property (@(posedge clk) disable iff (!rst_n)
      (div_sel == 4'h0 && $past(div_sel) == 4'h0 && $past(rst_n)) |-> tick)
      else $error("Undivided prescaler missed a tick");
endmodule // channel_divider
`default_nettype wire

// ### verilog/peripheral_event_router.sv
// Eight-channel peripheral event routing fabric
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Eight independent source selectors, each one event channel, run in parallel.
// - An event reaches the user outputs at most two clock cycles later.
// - Routing runs alike in active and idle sleep; nothing gates the clock.
// - Each channel prescaler divides the peripheral clock by 1 up to 32768.
// - Every channel owns its own divider, so intervals differ per channel.
// - Injection bit n acts on channel n; many bits inject together.
// - An injected event lasts one cycle and overrides the routed source.
// - Data users decode strobe/data as none, event 01, 02 or 03.
// - Signaling users see an event exactly when strobe is one.
// - Each user chooses data decoding or signaling decoding by configuration.
// - Signaling events carry nothing beyond the fact of a change.
// - Routed events are single-cycle pulses unless the source holds them.
// - Selector zero or an absent source routes nothing; injection still works.
module peripheral_event_router
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [31:0] source_strobe,
   input wire logic [31:0] source_data,
   input wire logic [63:0] channel_source_select,
   input wire logic [31:0] divider_select,
   input wire logic [7:0] inject_data,
   input wire logic inject_data_write,
   input wire logic [7:0] inject_strobe,
   input wire logic inject_strobe_write,
   input wire logic [7:0] user_data_mode,
   output logic [7:0] channel_strobe,
   output logic [7:0] channel_data,
   output logic [15:0] user_event,
   output logic [7:0] user_signal
);
   logic [7:0] strobe_q;
   logic [7:0] strobe_d;
   logic [7:0] data_q;
   logic [7:0] data_d;
   logic [7:0] inj_data_q;
   logic [7:0] inj_data_d;
   logic [15:0] user_event_q;
   logic [15:0] user_event_d;
   logic [7:0] user_signal_q;
   logic [7:0] user_signal_d;
   logic [7:0] tick;
   logic [7:0] route_strobe;
   logic [7:0] route_data;

   // =====================================================================
   // Channels
   genvar ch;
   generate
      for (ch = 0; ch < event_router_pkg::CHANNELS; ch++)
      begin : g_chan
         logic [7:0] sel;
         logic [7:0] idx;
         assign sel = channel_source_select[ch*8 +: 8];
         assign idx = sel - event_router_pkg::SEL_SOURCE_BASE;

         channel_divider u_div
         (
            .clk(clk),
            .rst_n(rst_n),
            .div_sel(divider_select[ch*4 +: 4]),
            .tick(tick[ch])
         );

         always_comb
         begin
            route_strobe[ch] = 1'b0;
            route_data[ch] = 1'b0;
            if (sel == event_router_pkg::SEL_PRESCALER)
            begin
               route_strobe[ch] = tick[ch];
            end
            else if (sel >= event_router_pkg::SEL_SOURCE_BASE &&
                     idx < 8'(event_router_pkg::SOURCES))
            begin
               route_strobe[ch] = source_strobe[idx[4:0]];
               route_data[ch] = source_data[idx[4:0]];
            end
            // Zero and absent selections route nothing
         end
      end
   endgenerate

   // =====================================================================
   // Injection, channel stage and user decode
   always_comb
   begin
      inj_data_d = inject_data_write ? inject_data : inj_data_q;
      strobe_d = route_strobe;
      data_d = route_data;
      for (int i = 0; i < 8; i++)
      begin
         if (inject_strobe_write && (inject_strobe[i] || inj_data_d[i]))
         begin
            strobe_d[i] = inject_strobe[i];
            data_d[i] = inj_data_d[i];
         end
      end
      user_event_d = 16'h0000;
      user_signal_d = strobe_q;
      for (int i = 0; i < 8; i++)
      begin
         if (user_data_mode[i])
         begin
            user_event_d[i*2 +: 2] = {strobe_q[i], data_q[i]};
         end
         else
         begin
            user_event_d[i*2 +: 2] = {strobe_q[i], 1'b0};
         end
      end
      if (!rst_n)
      begin
         inj_data_d = 8'h00;
         strobe_d = 8'h00;
         data_d = 8'h00;
         user_event_d = 16'h0000;
         user_signal_d = 8'h00;
      end
   end

   always_ff @(posedge clk)
   begin
      inj_data_q <= inj_data_d;
      strobe_q <= strobe_d;
      data_q <= data_d;
      user_event_q <= user_event_d;
      user_signal_q <= user_signal_d;
   end

   assign channel_strobe = strobe_q;
   assign channel_data = data_q;
   assign user_event = user_event_q;
   assign user_signal = user_signal_q;

   // =====================================================================
   // Checks
   inject_one_cycle_a: assert property (@(posedge clk) disable iff (!rst_n)
      (inject_strobe_write && inject_strobe[0]) ##1
      (!inject_strobe_write && channel_source_select[7:0] == event_router_pkg::SEL_NONE)
      |-> channel_strobe[0] ##1 !channel_strobe[0])
      else $error("Injected event lasted more than one cycle");
   inject_override_a: assert property (@(posedge clk) disable iff (!rst_n)
      (inject_strobe_write && inject_strobe[3]) |=> channel_strobe[3])
      else $error("Injected strobe not seen on channel");
   inject_data_a: assert property (@(posedge clk) disable iff (!rst_n)
      (inject_strobe_write && inject_strobe[5]) |=> channel_data[5] == $past(inj_data_d[5]))
      else $error("Injected data wrong on channel");
   zero_select_a: assert property (@(posedge clk) disable iff (!rst_n)
      (channel_source_select[7:0] == 8'h00 && !inject_strobe_write) |=> !channel_strobe[0])
      else $error("Channel with zero selector routed an event");
   route_latency_a: assert property (@(posedge clk) disable iff (!rst_n)
      (channel_source_select[15:8] == 8'h20 && source_strobe[0] && !inject_strobe_write)
      |-> ##2 user_signal[1]) else $error("Routed event late to user");
   signal_user_a: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 user_signal == $past(channel_strobe)) else $error("Signaling decode wrong");
   data_decode_a: assert property (@(posedge clk) disable iff (!rst_n)
      ($past(rst_n) && $past(user_data_mode[2]))
      |-> user_event[5:4] == $past({channel_strobe[2], channel_data[2]}))
      else $error("Data decode wrong");
   signal_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
      !$past(user_data_mode[6]) |-> !user_event[12]) else $error("Signal user saw data");
   reset_clear_a: assert property (@(posedge clk)
      !rst_n |=> (channel_strobe == 8'h00 && user_signal == 8'h00))
      else $error("Outputs not cleared by reset");
endmodule // peripheral_event_router
`default_nettype wire

// ### verification/event_source_model.sv
// Model of the event generators feeding the router
`timescale 1ns/1ps
`default_nettype none
module event_source_model
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [31:0] fire,
   input wire logic [31:0] fire_data,
   output logic [31:0] source_strobe,
   output logic [31:0] source_data
);
   // =====================================
   // One-cycle generator pulses, idle at no event
   always_ff @(posedge clk)
   begin
      source_strobe <= rst_n ? fire : 32'h0;
      source_data <= rst_n ? fire_data : 32'h0;
   end
endmodule // event_source_model
`default_nettype wire

// ### verification/tb.sv
// Self-checking bench for the event router
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
   num_checks++; \
   if ((got) !== (ex)) \
   begin \
      error_cnt++; \
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); \
   end
module tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [31:0] fire = 32'h0, fire_data = 32'h0, source_strobe, source_data, div = 32'h0;
   logic [63:0] sel = 64'h0;
   logic [7:0] idata = 8'h0, istrobe = 8'h0, mode = 8'h0, s, d, c0, c1, c2;
   logic idw = 1'b0, isw = 1'b0, watch = 1'b0;
   logic [7:0] channel_strobe, channel_data, user_signal;
   logic [15:0] user_event;
   logic [31:0] seed = 32'h664B, r;
   logic [39:0] nt, notes[$];
   int error_cnt = 0, num_checks = 0;
   always #4 clk = ~clk;
   event_source_model gen_u (.clk(clk), .rst_n(rst_n), .fire(fire), .fire_data(fire_data),
      .source_strobe(source_strobe), .source_data(source_data));
   peripheral_event_router dut_u (.clk(clk), .rst_n(rst_n), .source_strobe(source_strobe),
      .source_data(source_data), .channel_source_select(sel), .divider_select(div),
      .inject_data(idata), .inject_data_write(idw), .inject_strobe(istrobe),
      .inject_strobe_write(isw), .user_data_mode(mode), .channel_strobe(channel_strobe),
      .channel_data(channel_data), .user_event(user_event), .user_signal(user_signal));
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic note(input logic [7:0] es, input logic [7:0] ed);
      logic [15:0] ue;
      for (int n = 0; n < 8; n++)
      begin
         ue[2*n+1] = es[n];
         ue[2*n] = mode[n] & ed[n];
      end
      if ((es | ed) != 8'h0)
         notes.push_back({es, ed, ue, es});
   endtask
   task results();
      $display("Checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // =====================================
   // Watcher pairs each event with the oldest note
   always @(negedge clk)
      if (watch && (channel_strobe | channel_data) !== 8'h0)
      begin
         nt = (notes.size() > 0) ? notes.pop_front() : 40'h0;
         `CHK("channel strobe", nt[39:32], channel_strobe)
         `CHK("channel data", nt[31:24], channel_data)
         @(negedge clk);
         `CHK("user event", nt[23:8], user_event)
         `CHK("user signal", nt[7:0], user_signal)
      end
   // =====================================
   // Stimulus
   initial
   begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      `CHK("reset outputs", 40'h0, {channel_strobe, channel_data, user_event, user_signal})
      watch = 1'b1;
      for (int i = 0; i < 12; i++)
      begin
         @(posedge clk);
         s = 8'(rnd());
         d = 8'(rnd());
         mode <= 8'(rnd());
         idata <= d;
         idw <= 1'b1;
         @(posedge clk);
         note(s, d);
         idw <= 1'b0;
         istrobe <= s;
         isw <= 1'b1;
         @(posedge clk);
         isw <= 1'b0;
         repeat (3) @(posedge clk);
      end
      for (int i = 0; i < 10; i++)
      begin
         r = (i == 0) ? 32'h00000020 : rnd();
         sel <= {8{8'hFF}} & ~(64'hFF << (8 * r[7:5])) | (64'(8'h20 + r[4:0]) << (8 * r[7:5]));
         @(posedge clk);
         fire <= 32'h1 << r[4:0];
         fire_data <= 32'(r[9]) << r[4:0];
         if (r[8])
            note(8'h0, 8'h1 << r[7:5]);
         else
            note(8'h1 << r[7:5], 8'(r[9]) << r[7:5]);
         @(posedge clk);
         fire <= 32'h0;
         fire_data <= 32'h0;
         idata <= 8'h1 << r[7:5];
         istrobe <= 8'h0;
         idw <= r[8];
         isw <= r[8];
         @(posedge clk);
         idw <= 1'b0;
         isw <= 1'b0;
         repeat (4) @(posedge clk);
      end
      watch = 1'b0;
      sel <= 64'h0000000000010101;
      div <= 32'h00000032;
      {c0, c1, c2} = 24'h0;
      repeat (20) @(posedge clk);
      repeat (64)
      begin
         @(negedge clk);
         c0 = c0 + 8'(channel_strobe[0]);
         c1 = c1 + 8'(channel_strobe[1]);
         c2 = c2 + 8'(channel_strobe[2]);
      end
      `CHK("ticks div 4", 8'h10, c0)
      `CHK("ticks div 8", 8'h08, c1)
      `CHK("ticks div 1", 8'h40, c2)
      `CHK("notes left", 0, notes.size())
      results();
   end
   initial
   begin
      repeat (3000) @(posedge clk);
      error_cnt++;
      results();
   end
endmodule // tb
`default_nettype wire
